// file: rtl/acp_cfg_top.sv
// acp_cfg_top: mode pins, serial register port and lane framing
module acp_cfg_top (
	input wire logic sys_clk_in,
	input wire logic rst_n_in,
	input wire logic [1:0] mode_pin_in,
	input wire logic hw_reset_pin_in,
	input wire logic [1:0] enable_or_align_pin_in,
	input wire logic [1:0] clock_or_lane_pin_in,
	input wire logic data_in_or_pattern_lo_pin_in,
	input wire logic data_out_or_pattern_hi_pin_in,
	output logic data_out_or_pattern_hi_pin_out,
	output logic data_out_or_pattern_hi_pin_oe_out,
	input wire logic sync_request_in,
	input wire logic sample_valid_in,
	input wire logic [15:0] sample_in,
	input wire logic [3:0] early_estimate_in,
	input wire logic [3:0] power_estimate_in,
	output logic [3:0] estimate_out,
	output logic serial_mode_out,
	output logic frame_end_marker_enable_out,
	output logic sync_char_select_out,
	output logic octets_per_frame_select_out,
	output logic whitening_enable_out,
	output logic lane_valid_out,
	output logic [15:0] lane0_data_out,
	output logic [1:0] lane0_k_out,
	output logic [7:0] lane1_data_out,
	output logic lane1_k_out
);
	localparam int SYNC_W = 10;
	logic [SYNC_W-1:0] pins_raw, sync1_q, sync2_q;
	logic [1:0] mode_s, ea_s, cl_s;
	logic sdi_s, hi_s, hwr_s, syncreq_s, sen_s, sclk_s;
	logic sclk_prev_q, serial_mode_w, fall;
	logic ea_first, ea_second, cl_first, cl_second;
	acp_pkg::acp_sp_state_t sp_q, sp_d;
	logic [3:0] cnt_q, cnt_d;
	logic [15:0] shift_q, shift_d, word;
	logic [7:0] rds_q, rds_d, rd_val, addr_w;
	logic sdo_q, sdo_d, oe_q, word_done;
	logic readback_q, readback_d, soft_init_q, soft_init_d;
	logic [7:0] cfg_q, cfg_d;
	logic align_q, align_d, syncsel_q, syncsel_d, opf_q, opf_d;
	logic whiten_q, whiten_d, serial_q;
	logic [1:0] pat_q, pat_d;
	logic [3:0] est_q, est_d;
	logic [15:0] src, l0_q, l0_d, prbs_w;
	logic [7:0] l1_q, l1_d, p0_q, p0_d, p1_q, p1_d, hi, lo, dch;
	logic [1:0] k0_q, k0_d, ph_q, ph_d;
	logic k1_q, k1_d, lv_q, lv_d, whitening_enable;
	logic [14:0] s0_q, s0_d, s1_q, s1_d;
	logic [22:0] r1, r2;

	// every pin is outside this clock: two flops before use
	assign pins_raw = {mode_pin_in, enable_or_align_pin_in,
		clock_or_lane_pin_in, data_in_or_pattern_lo_pin_in,
		data_out_or_pattern_hi_pin_in, hw_reset_pin_in, sync_request_in};
	assign {mode_s, ea_s, cl_s, sdi_s, hi_s, hwr_s, syncreq_s} = sync2_q;
	// serial logic level is the top bit of the quantised pin level
	assign sen_s = ea_s[1];
	assign sclk_s = cl_s[1];
	assign serial_mode_w = (mode_s != acp_pkg::LVL_5_8);
	// falling edge, any rate or duty
	assign fall = sclk_prev_q & ~sclk_s;
	assign addr_w = {shift_q[6:0], sdi_s};

	acp_level_dec u_ea_dec (
		.code_in(ea_s),
		.first_out(ea_first),
		.second_out(ea_second)
	);

	acp_level_dec u_cl_dec (
		.code_in(cl_s),
		.first_out(cl_first),
		.second_out(cl_second)
	);

	acp_prbs #(.W(16)) u_prbs (
		.sys_clk_in(sys_clk_in),
		.rst_n_in(rst_n_in),
		.step_in(sample_valid_in),
		.word_out(prbs_w)
	);

	always_comb begin
		rd_val = 8'h00;
		if (addr_w == acp_pkg::ADDR_CTRL) begin
			rd_val[acp_pkg::CTRL_READBACK_BIT] = readback_q;
			rd_val[acp_pkg::CTRL_SOFT_INIT_BIT] = soft_init_q;
		end else if (addr_w == acp_pkg::ADDR_CFG) begin
			rd_val = cfg_q;
		end
	end

	always_comb begin
		sp_d = sp_q;
		cnt_d = cnt_q;
		shift_d = shift_q;
		rds_d = rds_q;
		sdo_d = sdo_q;
		word_done = 1'b0;
		word = 16'h0000;
		if (!serial_mode_w || sen_s) begin
			sp_d = acp_pkg::SP_OFF;
			cnt_d = 4'h0;
		end else begin
			sp_d = acp_pkg::SP_SHIFT;
			if (fall) begin
				shift_d = {shift_q[acp_pkg::WORD_BITS-2:0], sdi_s};
				cnt_d = cnt_q + 4'h1;
				if (cnt_q == acp_pkg::WORD_LAST) begin
					word_done = 1'b1;
					word = shift_d;
				end
				// next bit set up right after an edge, stable at the next
				if (cnt_q == acp_pkg::ADDR_LAST) begin
					sdo_d = rd_val[7];
					rds_d = {rd_val[6:0], 1'b0};
				end else if (cnt_q > acp_pkg::ADDR_LAST &&
					cnt_q < acp_pkg::WORD_LAST) begin
					sdo_d = rds_q[7];
					rds_d = {rds_q[6:0], 1'b0};
				end
			end
		end
	end

	always_comb begin
		readback_d = readback_q;
		soft_init_d = soft_init_q;
		cfg_d = cfg_q;
		// reset pin; soft init then self-clear
		if (hwr_s || soft_init_q) begin
			readback_d = 1'b0;
			soft_init_d = 1'b0;
			cfg_d = acp_pkg::CFG_RESET;
		end else if (word_done) begin
			if (word[15:8] == acp_pkg::ADDR_CTRL) begin
				readback_d = word[acp_pkg::CTRL_READBACK_BIT];
				if (!readback_q)
					soft_init_d = word[acp_pkg::CTRL_SOFT_INIT_BIT];
			end else if (word[15:8] == acp_pkg::ADDR_CFG && !readback_q) begin
				cfg_d = word[7:0];
			end
		end
	end

	always_comb begin
		if (serial_mode_w) begin
			align_d = cfg_q[acp_pkg::CFG_ALIGN_BIT];
			syncsel_d = cfg_q[acp_pkg::CFG_SYNC_SEL_BIT];
			opf_d = cfg_q[acp_pkg::CFG_OPF_BIT];
			whiten_d = cfg_q[acp_pkg::CFG_WHITEN_BIT];
			pat_d = {cfg_q[acp_pkg::CFG_PAT_HI_BIT],
				cfg_q[acp_pkg::CFG_PAT_LO_BIT]};
		end else begin
			align_d = ea_first;
			syncsel_d = ea_second;
			opf_d = cl_first;
			whiten_d = cl_second;
			pat_d = {hi_s, sdi_s};
		end
		if (serial_mode_w && cfg_q[acp_pkg::CFG_EST_SEL_BIT])
			est_d = power_estimate_in;
		else
			est_d = early_estimate_in;
	end

	always_comb begin
		l0_d = l0_q;
		k0_d = k0_q;
		l1_d = l1_q;
		k1_d = k1_q;
		lv_d = 1'b0;
		s0_d = s0_q;
		s1_d = s1_q;
		p0_d = p0_q;
		p1_d = p1_q;
		ph_d = ph_q;
		unique case (pat_q)
			acp_pkg::PAT_SAMPLES: src = sample_in;
			acp_pkg::PAT_SEL_B5B5: src = acp_pkg::PAT_B5B5;
			acp_pkg::PAT_SEL_FF00: src = acp_pkg::PAT_FF00;
			acp_pkg::PAT_SEL_PRBS: src = prbs_w;
		endcase
		whitening_enable = whiten_q && (pat_q != acp_pkg::PAT_SEL_PRBS);
		r1 = acp_pkg::acp_scr8(src[15:8], s0_q);
		r2 = acp_pkg::acp_scr8(src[7:0], opf_q ? s1_q : r1[22:8]);
		hi = whitening_enable ? r1[7:0] : src[15:8];
		lo = whitening_enable ? r2[7:0] : src[7:0];
		dch = ph_q[1] ? acp_pkg::D16_2 : acp_pkg::D5_6;
		if (sample_valid_in) begin
			lv_d = 1'b1;
			if (syncreq_s) begin
				ph_d = ph_q + 2'h1;
				if (!syncsel_q) begin
					l0_d = {acp_pkg::K28_5, acp_pkg::K28_5};
					k0_d = 2'h3;
					l1_d = acp_pkg::K28_5;
					k1_d = 1'b1;
				end else if (!opf_q) begin
					l0_d = {acp_pkg::K28_5,
						ph_q[0] ? acp_pkg::D16_2 : acp_pkg::D5_6};
					k0_d = 2'h2;
					l1_d = 8'h00;
					k1_d = 1'b0;
				end else if (ph_q[0]) begin
					l0_d = {8'h00, dch};
					k0_d = 2'h0;
					l1_d = dch;
					k1_d = 1'b0;
				end else begin
					l0_d = {8'h00, acp_pkg::K28_5};
					k0_d = 2'h1;
					l1_d = acp_pkg::K28_5;
					k1_d = 1'b1;
				end
			end else begin
				ph_d = 2'h0;
				if (whitening_enable) begin
					s0_d = opf_q ? r1[22:8] : r2[22:8];
					if (opf_q)
						s1_d = r2[22:8];
				end
				if (!opf_q) begin
					l0_d = {hi, lo};
					k0_d = 2'h0;
					l1_d = 8'h00;
					k1_d = 1'b0;
					p0_d = src[7:0];
					if (align_q && src[7:0] == p0_q) begin
						l0_d[7:0] = acp_pkg::K28_7;
						k0_d[0] = 1'b1;
					end
				end else begin
					l0_d = {8'h00, hi};
					k0_d = 2'h0;
					l1_d = lo;
					k1_d = 1'b0;
					p0_d = src[15:8];
					p1_d = src[7:0];
					if (align_q && src[15:8] == p0_q) begin
						l0_d[7:0] = acp_pkg::K28_7;
						k0_d[0] = 1'b1;
					end
					if (align_q && src[7:0] == p1_q) begin
						l1_d = acp_pkg::K28_7;
						k1_d = 1'b1;
					end
				end
			end
		end
	end

	always_ff @(posedge sys_clk_in or negedge rst_n_in) begin
		if (!rst_n_in) begin
			sync1_q <= '0;
			sync2_q <= '0;
			sclk_prev_q <= 1'b0;
			sp_q <= acp_pkg::SP_OFF;
			cnt_q <= 4'h0;
			shift_q <= 16'h0000;
			rds_q <= 8'h00;
			sdo_q <= 1'b0;
			oe_q <= 1'b0;
			readback_q <= 1'b0;
			soft_init_q <= 1'b0;
			cfg_q <= acp_pkg::CFG_RESET;
			align_q <= 1'b0;
			syncsel_q <= 1'b0;
			opf_q <= 1'b0;
			whiten_q <= 1'b0;
			pat_q <= acp_pkg::PAT_SAMPLES;
			serial_q <= 1'b1;
			est_q <= 4'h0;
			l0_q <= 16'h0000;
			k0_q <= 2'h0;
			l1_q <= 8'h00;
			k1_q <= 1'b0;
			lv_q <= 1'b0;
			s0_q <= '0;
			s1_q <= '0;
			p0_q <= 8'h00;
			p1_q <= 8'h00;
			ph_q <= 2'h0;
		end else begin
			sync1_q <= pins_raw;
			sync2_q <= sync1_q;
			sclk_prev_q <= sclk_s;
			sp_q <= sp_d;
			cnt_q <= cnt_d;
			shift_q <= shift_d;
			rds_q <= rds_d;
			sdo_q <= sdo_d;
			// pin driven only in serial readback
			oe_q <= serial_mode_w && readback_d;
			readback_q <= readback_d;
			soft_init_q <= soft_init_d;
			cfg_q <= cfg_d;
			align_q <= align_d;
			syncsel_q <= syncsel_d;
			opf_q <= opf_d;
			whiten_q <= whiten_d;
			pat_q <= pat_d;
			serial_q <= serial_mode_w;
			est_q <= est_d;
			l0_q <= l0_d;
			k0_q <= k0_d;
			l1_q <= l1_d;
			k1_q <= k1_d;
			lv_q <= lv_d;
			s0_q <= s0_d;
			s1_q <= s1_d;
			p0_q <= p0_d;
			p1_q <= p1_d;
			ph_q <= ph_d;
		end
	end

	assign data_out_or_pattern_hi_pin_out = sdo_q;
	assign data_out_or_pattern_hi_pin_oe_out = oe_q;
	assign estimate_out = est_q;
	assign serial_mode_out = serial_q;
	assign frame_end_marker_enable_out = align_q;
	assign sync_char_select_out = syncsel_q;
	assign octets_per_frame_select_out = opf_q;
	assign whitening_enable_out = whiten_q;
	assign lane_valid_out = lv_q;
	assign lane0_data_out = l0_q;
	assign lane0_k_out = k0_q;
	assign lane1_data_out = l1_q;
	assign lane1_k_out = k1_q;

	default clocking cb @(posedge sys_clk_in);
	endclocking
	default disable iff (!rst_n_in);

	sequence s_rb_addr_done;
		serial_mode_w && !sen_s && readback_q && fall &&
			cnt_q == acp_pkg::ADDR_LAST && addr_w == acp_pkg::ADDR_CFG;
	endsequence

	a_readback_msb: assert property (
		s_rb_addr_done |=> data_out_or_pattern_hi_pin_out == $past(cfg_q[7])
			&& data_out_or_pattern_hi_pin_oe_out)
		else $error("readback msb wrong after address");
	a_write_blocked: assert property (
		readback_q && !hwr_s && !soft_init_q |=> $stable(cfg_q))
		else $error("config changed during readback");
	a_soft_init_clear: assert property (
		soft_init_q |=> !soft_init_q && !readback_q
			&& cfg_q == acp_pkg::CFG_RESET)
		else $error("soft init did not load defaults and clear");
	a_no_partial_commit: assert property (
		!(fall && cnt_q == acp_pkg::WORD_LAST) && !hwr_s && !soft_init_q
			|=> $stable(cfg_q) && $stable(readback_q))
		else $error("register changed off a word boundary");
	a_enable_restart: assert property (
		sen_s |=> cnt_q == 4'h0 && sp_q == acp_pkg::SP_OFF)
		else $error("bit count not restarted");
	a_align_decode: assert property (
		mode_s == acp_pkg::LVL_5_8 && ea_s == acp_pkg::LVL_3_8
			|=> frame_end_marker_enable_out && !sync_char_select_out)
		else $error("align pin decode wrong");
	a_lane_decode: assert property (
		mode_s == acp_pkg::LVL_5_8 && cl_s == acp_pkg::LVL_FULL
			|=> !octets_per_frame_select_out && whitening_enable_out)
		else $error("lane pin decode wrong");
	a_estimate_par: assert property (
		mode_s == acp_pkg::LVL_5_8 |=> estimate_out == $past(early_estimate_in))
		else $error("parallel mode estimate not early estimate");
	a_sync_plain: assert property (
		sample_valid_in && syncreq_s && !syncsel_q
			|=> lane0_data_out == {acp_pkg::K28_5, acp_pkg::K28_5}
			&& lane0_k_out == 2'h3 && lane_valid_out)
		else $error("sync characters wrong");
	a_frame_marker: assert property (
		sample_valid_in && !syncreq_s && align_q && !opf_q && !whiten_q
			&& pat_q == acp_pkg::PAT_SEL_B5B5 && p0_q == 8'hb5
			|=> lane0_data_out[7:0] == acp_pkg::K28_7 && lane0_k_out[0])
		else $error("frame-end marker missing");
endmodule // acp_cfg_top

// file: pkg/acp_pkg.sv
// acp_pkg: shared constants, types and the lane scrambler step
// What this block does
// - mode pin near ground selects serial mode; near five-eighths selects parallel.
// - parallel: enable/align pin level decodes frame-end marker and sync-character options.
// - repeated frame-last octet becomes K28.7 when frame-end marker is enabled.
// - sync request sends K28.5, or K28.5 alternating with D5.6/D16.2.
// - octets-per-frame 0: two octets, one lane; 1: one octet, two lanes.
// - whitening enabled scrambles lane data with the standard polynomial.
// - pattern pins pick samples, constant B5B5 or constant FF00.
// - both pattern pins high feed the pseudo-random sequence, never scrambled.
// - estimate pins: parallel gives early estimate, serial picks by register.
// - serial data is sampled on serial clock falling edges while enable low.
// - every 16th falling edge in one enable period commits a word.
// - bits beyond the last complete word are dropped without effect.
// - each word is eight address bits then eight data bits.
// - serial clock may run from a few hertz to 20 MHz, any duty.
// - reset pin high pulse loads all defaults.
// - writing soft-init bit loads defaults, then the bit clears itself.
// - while readback is on, only the readback bit may be written.
// - in readback, the addressed register's data shifts out on the output pin.
// - readback bit is bit 0 of register 00, default 0.
package acp_pkg;
	localparam logic [1:0] LVL_GND = 2'h0;
	localparam logic [1:0] LVL_3_8 = 2'h1;
	localparam logic [1:0] LVL_5_8 = 2'h2;
	localparam logic [1:0] LVL_FULL = 2'h3;
	localparam int WORD_BITS = 16;
	localparam logic [3:0] ADDR_LAST = 4'h7;
	localparam logic [3:0] WORD_LAST = 4'hf;
	localparam logic [7:0] ADDR_CTRL = 8'h00;
	localparam logic [7:0] ADDR_CFG = 8'h01;
	localparam int CTRL_READBACK_BIT = 0;
	localparam int CTRL_SOFT_INIT_BIT = 1;
	localparam int CFG_EST_SEL_BIT = 0;
	localparam int CFG_ALIGN_BIT = 1;
	localparam int CFG_SYNC_SEL_BIT = 2;
	localparam int CFG_OPF_BIT = 3;
	localparam int CFG_WHITEN_BIT = 4;
	localparam int CFG_PAT_LO_BIT = 5;
	localparam int CFG_PAT_HI_BIT = 6;
	localparam logic [7:0] CFG_RESET = 8'h00;
	localparam logic [7:0] K28_5 = 8'hbc;
	localparam logic [7:0] K28_7 = 8'hfc;
	localparam logic [7:0] D5_6 = 8'hc5;
	localparam logic [7:0] D16_2 = 8'h50;
	localparam logic [1:0] PAT_SAMPLES = 2'h0;
	localparam logic [1:0] PAT_SEL_B5B5 = 2'h1;
	localparam logic [1:0] PAT_SEL_FF00 = 2'h2;
	localparam logic [1:0] PAT_SEL_PRBS = 2'h3;
	localparam logic [15:0] PAT_B5B5 = 16'hb5b5;
	localparam logic [15:0] PAT_FF00 = 16'hff00;
	localparam logic [14:0] PRBS_SEED = 15'h7fff;

	typedef enum logic {SP_OFF, SP_SHIFT} acp_sp_state_t;

	// one octet through the 1+x^14+x^15 scrambler: {next state, octet}
	function automatic logic [22:0] acp_scr8(input logic [7:0] d,
		input logic [14:0] s);
		logic [14:0] st;
		logic [7:0] o;
		logic b;
		st = s;
		o = 8'h00;
		for (int i = 7; i >= 0; i--) begin
			b = d[i] ^ st[13] ^ st[14];
			o[i] = b;
			st = {st[13:0], b};
		end
		return {st, o};
	endfunction
endpackage

// file: rtl/acp_level_dec.sv
// acp_level_dec: four-level pin code to two option bits
module acp_level_dec (
	input wire logic [1:0] code_in,
	output logic first_out,
	output logic second_out
);
	always_comb begin
		unique case (code_in)
			acp_pkg::LVL_GND: {first_out, second_out} = 2'h0;
			acp_pkg::LVL_3_8: {first_out, second_out} = 2'h2;
			acp_pkg::LVL_5_8: {first_out, second_out} = 2'h3;
			acp_pkg::LVL_FULL: {first_out, second_out} = 2'h1;
		endcase
	end
endmodule // acp_level_dec

// file: rtl/acp_prbs.sv
// acp_prbs: 1+x^14+x^15 pattern source, W new bits per step
module acp_prbs #(
	parameter int W = 16
) (
	input wire logic sys_clk_in,
	input wire logic rst_n_in,
	input wire logic step_in,
	output logic [W-1:0] word_out
);
	logic [14:0] st_q, st_d;
	logic [W-1:0] word_q, word_d;
	logic [14:0] st;
	logic b;

	always_comb begin
		st = st_q;
		b = 1'b0;
		word_d = word_q;
		st_d = st_q;
		if (step_in) begin
			for (int i = W - 1; i >= 0; i--) begin
				b = st[14] ^ st[13];
				word_d[i] = b;
				st = {st[13:0], b};
			end
			st_d = st;
		end
	end

	always_ff @(posedge sys_clk_in or negedge rst_n_in) begin
		if (!rst_n_in) begin
			st_q <= acp_pkg::PRBS_SEED;
			word_q <= '0;
		end else begin
			st_q <= st_d;
			word_q <= word_d;
		end
	end

	assign word_out = word_q;
endmodule // acp_prbs

// file: sim/acp_ctrl_model.sv
// acp_ctrl_model: external controller driving the serial config port
module acp_ctrl_model (
	input wire logic sys_clk_in,
	input wire logic serial_out_pin_in,
	output logic sen_n_out,
	output logic sclk_out,
	output logic serial_in_pin_out
);
	timeunit 1ns;
	timeprecision 1ps;
	// 8 sys cycles a phase gives the 64 ns link clock
	localparam int HALF = 8;
	logic [7:0] rd_q;
	// clock idles high, standing still between frames
	initial begin
		sen_n_out = 1'b1;
		sclk_out = 1'b1;
		serial_in_pin_out = 1'b0;
		rd_q = 8'h00;
	end
	task automatic wait_cyc(input int n);
		repeat (n) @(posedge sys_clk_in);
	endtask
	// enable low, msb first, data set while clock high
	task automatic send(input logic [39:0] w, input int nbits);
		wait_cyc(1);
		sen_n_out <= 1'b0;
		for (int i = 0; i < nbits; i++) begin
			serial_in_pin_out <= w[39 - i];
			wait_cyc(HALF);
			// readback bit taken at the falling edge
			rd_q <= {rd_q[6:0], serial_out_pin_in};
			sclk_out <= 1'b0;
			wait_cyc(HALF);
			sclk_out <= 1'b1;
		end
		wait_cyc(HALF);
		sen_n_out <= 1'b1;
		// released line must not keep showing the last bit
		serial_in_pin_out <= ~serial_in_pin_out;
		wait_cyc(HALF);
	endtask
endmodule // acp_ctrl_model

// file: sim/acp_cfg_top_bench.sv
// acp_cfg_top_bench: self-checking bench for the config block
module acp_cfg_top_bench;
	timeunit 1ns;
	timeprecision 1ps;
	logic sys_clk_in = 1'b0;
	logic rst_n_in = 1'b0;
	logic [1:0] mode_q = 2'h0;
	logic hw_rst_q = 1'b0;
	logic [1:0] eoa_q = 2'h0;
	logic [1:0] col_q = 2'h0;
	logic pat_lo_q = 1'b0;
	logic pat_hi_q = 1'b0;
	logic sync_q = 1'b0;
	logic valid_q = 1'b0;
	logic [15:0] smp_q = 16'h0000;
	logic [3:0] early = 4'h5;
	logic [3:0] power = 4'ha;
	logic sen_n, sclk, serial_in_pin, sdo, sdo_oe;
	logic [3:0] est;
	logic ser, fem, scs, opf, wht, lv, l1k;
	logic [15:0] l0d;
	logic [1:0] l0k;
	logic [7:0] l1d;
	wire par = (mode_q == 2'h2);
	wire [1:0] eoa = par ? eoa_q : {sen_n, sen_n};
	wire [1:0] col = par ? col_q : {sclk, sclk};
	wire din = par ? pat_lo_q : serial_in_pin;
	wire sdo_pin = sdo_oe ? sdo : pat_hi_q;
	int n_errors = 0;
	int n_checks = 0;

	always #2 sys_clk_in = ~sys_clk_in;

	acp_cfg_top dut (
		.sys_clk_in(sys_clk_in), .rst_n_in(rst_n_in),
		.mode_pin_in(mode_q), .hw_reset_pin_in(hw_rst_q),
		.enable_or_align_pin_in(eoa), .clock_or_lane_pin_in(col),
		.data_in_or_pattern_lo_pin_in(din),
		.data_out_or_pattern_hi_pin_in(sdo_pin),
		.data_out_or_pattern_hi_pin_out(sdo),
		.data_out_or_pattern_hi_pin_oe_out(sdo_oe),
		.sync_request_in(sync_q), .sample_valid_in(valid_q),
		.sample_in(smp_q), .early_estimate_in(early),
		.power_estimate_in(power), .estimate_out(est),
		.serial_mode_out(ser), .frame_end_marker_enable_out(fem),
		.sync_char_select_out(scs), .octets_per_frame_select_out(opf),
		.whitening_enable_out(wht), .lane_valid_out(lv),
		.lane0_data_out(l0d), .lane0_k_out(l0k),
		.lane1_data_out(l1d), .lane1_k_out(l1k)
	);

	acp_ctrl_model ctl (
		.sys_clk_in(sys_clk_in), .serial_out_pin_in(sdo_pin),
		.sen_n_out(sen_n), .sclk_out(sclk), .serial_in_pin_out(serial_in_pin)
	);

	task automatic chk(input string nm, input logic [15:0] got,
		input logic [15:0] exp);
		n_checks++;
		if (got !== exp) begin
			n_errors++;
			$display("ERROR %s expected %h seen %h", nm, exp, got);
		end
	endtask
	task automatic give_verdict();
		if (n_errors == 0 && n_checks > 0) begin
			$display("ALL TESTS PASSED");
		end else begin
			$display("TESTS FAILED");
		end
		$finish;
	endtask
	task automatic cyc(input int n);
		repeat (n) @(posedge sys_clk_in);
	endtask
	task automatic wr(input logic [7:0] a, input logic [7:0] d);
		ctl.send({a, d, 24'h000000}, 16);
		cyc(8);
	endtask
	// data byte lets readback bit be kept on while reading
	task automatic rd(input logic [7:0] a, input logic [7:0] d,
		input logic [7:0] exp);
		ctl.send({a, d, 24'h000000}, 16);
		chk("readback", {8'h00, ctl.rd_q}, {8'h00, exp});
	endtask
	task automatic opts(input logic [3:0] exp);
		@(negedge sys_clk_in);
		chk("options", {12'h000, fem, scs, opf, wht}, {12'h000, exp});
	endtask
	task automatic frame(input logic [15:0] s);
		@(posedge sys_clk_in);
		valid_q <= 1'b1;
		smp_q <= s;
		@(posedge sys_clk_in);
		valid_q <= 1'b0;
		@(negedge sys_clk_in);
		chk("lane_valid", {15'h0000, lv}, 16'h0001);
	endtask

	initial begin
		#300us;
		n_errors++;
		give_verdict();
	end

	initial begin
		cyc(5);
		@(negedge sys_clk_in);
		chk("reset_state", {10'h000, ser, fem, scs, opf, wht, sdo_oe},
			16'h0020);
		// power-up wait shortened to the reset hold
		cyc(1);
		rst_n_in <= 1'b1;
		// at least 100 ns before enable falls
		cyc(25);
		wr(8'h01, 8'h1f);
		opts(4'hf);
		chk("est_serial", {12'h000, est}, 16'h000a);
		ctl.send({8'h01, 8'h02, 8'h01, 8'h04, 8'hff}, 37);
		cyc(8);
		opts(4'h4);
		ctl.send({8'h01, 8'hff, 24'h000000}, 10);
		cyc(8);
		opts(4'h4);
		wr(8'h01, 8'h08);
		opts(4'h2);
		wr(8'h00, 8'h02);
		opts(4'h0);
		wr(8'h01, 8'h08);
		wr(8'h00, 8'h01);
		chk("oe_on", {15'h0000, sdo_oe}, 16'h0001);
		rd(8'h01, 8'h00, 8'h08);
		rd(8'h01, 8'h00, 8'h08);
		rd(8'h00, 8'h01, 8'h01);
		rd(8'h05, 8'h01, 8'h00);
		wr(8'h00, 8'h00);
		chk("oe_off", {15'h0000, sdo_oe}, 16'h0000);
		wr(8'h01, 8'h1f);
		hw_rst_q <= 1'b1;
		cyc(3);
		hw_rst_q <= 1'b0;
		cyc(8);
		opts(4'h0);
		cyc(25);
		mode_q <= 2'h2;
		for (int l = 0; l < 4; l++) begin
			cyc(1);
			eoa_q <= 2'(l);
			col_q <= 2'(l);
			cyc(8);
			opts({l == 1 || l == 2, l >= 2, l == 1 || l == 2, l >= 2});
		end
		chk("mode", {15'h0000, ser}, 16'h0000);
		chk("est_par", {12'h000, est}, 16'h0005);
		cyc(1);
		eoa_q <= 2'h1;
		col_q <= 2'h0;
		sync_q <= 1'b1;
		cyc(8);
		frame(16'h0000);
		chk("sync", {l0d[15:8], l0d[7:0]},
			{acp_pkg::K28_5, acp_pkg::K28_5});
		chk("sync_k", {14'h0000, l0k}, 16'h0003);
		cyc(1);
		sync_q <= 1'b0;
		for (int p = 1; p < 3; p++) begin
			cyc(1);
			{pat_hi_q, pat_lo_q} <= 2'(p);
			cyc(8);
			frame(16'h1234);
			chk("pattern", l0d, p == 1 ? acp_pkg::PAT_B5B5
				: acp_pkg::PAT_FF00);
			if (p == 1) begin
				frame(16'h1234);
				chk("marker_b5", l0d, {8'hb5, acp_pkg::K28_7});
			end
		end
		cyc(1);
		{pat_hi_q, pat_lo_q} <= 2'h0;
		cyc(8);
		frame(16'h1234);
		chk("samples", l0d, 16'h1234);
		frame(16'h5634);
		chk("marker", l0d, {8'h56, acp_pkg::K28_7});
		chk("marker_k", {14'h0000, l0k}, 16'h0001);
		cyc(1);
		col_q <= 2'h1;
		cyc(8);
		frame(16'habcd);
		chk("two_lane", {l0d[7:0], l1d}, 16'habcd);
		chk("two_lane_k", {13'h0000, l0k, l1k}, 16'h0000);
		cyc(4);
		give_verdict();
	end
endmodule // acp_cfg_top_bench
